//--- logic/port_pin_function_select.sv
// pin-function multiplexer for port b pins 0..3 and port c pins 0..5, port registers and wake
`timescale 1ns/1ps
// Behaviour
// RQ1: pb3 field 01 routes timer0_out; other codes keep I/O with timer0 clock and irq1.
// RQ2: software points irq1 source at pb3 before selecting that pin.
// RQ3: pb2 field: 00 I/O with cap/clk inputs, 01 timer1, 10 analog0, 11 hall c.
// RQ4: pb1 field: 00 I/O with capture/timer2 clock, 01 timer1, 10 analog1, 11 hall b.
// RQ5: software sets capture timer source to pb1 before selecting it.
// RQ6: pb0 field: 00/01 I/O with irq1 and filter, 10 analog2, 11 hall a.
// RQ7: software sets irq1 or filter source to pb0 before selecting it.
// RQ8: pc3 field: 01 timer2, 10 gate b bottom, else plain I/O.
// RQ9: pc2 field: 01 timer2, 10 gate b top, else plain I/O.
// RQ10: pc1 field: 01 timer0, 10 gate a bottom, else plain I/O.
// RQ11: pc0 field: 01 timer0, 10 gate a top, else plain I/O.
// RQ12: pc5 field: 01 timer3, 10 gate c bottom, else plain I/O.
// RQ13: pc4 field: 01 timer3, 10 gate c top, else plain I/O.
// RQ14: upper port c select bits 7..4 ignore writes and read zero.
// RQ15: reset loads all port data and direction registers with ones.
// RQ16: a pin turned output drives high unless its data bit was written.
// RQ17: bit set/clear reads whole port, changes one bit, writes full byte.
// RQ18: falling edge on a wake-enabled port a pin wakes the device in sleep.
// RQ19: software sets pin selection before using a timer pin function.
// RQ20: direction bit 0 makes the pin an output, 1 an input.
// RQ21: irq1 source: 00/11 pa7, 01 pb3, 10 pb0.
// RQ22: capture source bit: 0 pb1, 1 pa6.
// RQ23: filter source: 00/11 pa7, 01 pa6, 10 pb0.
// RQ24: selection changes routing at next clock edge and holds until rewritten; the registered pins change on the second edge after the write.
module port_pin_function_select
   import pin_mux_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [3:0]  regAddr,
   input  wire logic [7:0]  regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic [7:0]       regRdata,
   input  wire logic [7:0]  portaIn,
   input  wire logic [3:0]  portbIn,
   input  wire logic [5:0]  portcIn,
   output logic [7:0]       portaOut,
   output logic [7:0]       portaOe,
   output logic [3:0]       portbOut,
   output logic [3:0]       portbOe,
   output logic [5:0]       portcOut,
   output logic [5:0]       portcOe,
   input  wire periph_out_s periphOut,
   output periph_in_s       periphIn,
   output analog_en_s       analogEn,
   input  wire logic        sleepMode,
   output logic             wakeReq
);

   // ************************************************************
   // register file
   // ************************************************************
   logic [7:0] pbSel_ff, pcSelLo_ff, pcSelHi_ff, srcSel_ff;
   logic [7:0] paData_ff, paDir_ff, pbData_ff, pbDir_ff, pcData_ff, pcDir_ff;
   logic [7:0] paWake_ff;

   // selection registers; each field holds until written again [RQ24]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pbSel_ff   <= RST_SEL;
         pcSelLo_ff <= RST_SEL;
         pcSelHi_ff <= RST_SEL;
         srcSel_ff  <= RST_SEL;
      end else if (regWr) begin
         unique case (regAddr)
            OFS_PB_SEL:    pbSel_ff   <= regWdata;
            OFS_PC_SEL_LO: pcSelLo_ff <= regWdata;
            OFS_PC_SEL_HI: pcSelHi_ff <= regWdata & MASK_PC_HI; // [RQ14]
            OFS_SRC_SEL:   srcSel_ff  <= regWdata & MASK_SRC;
            default: ;
         endcase
      end
   end

   // port data and direction start at ones: inputs, high latch [RQ15]
   // a data bit never written stays one, so a new output drives high [RQ16]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         paData_ff <= RST_PORT;
         paDir_ff  <= RST_PORT;
         pbData_ff <= RST_PORT;
         pbDir_ff  <= RST_PORT;
         pcData_ff <= RST_PORT;
         pcDir_ff  <= RST_PORT;
      end else if (regWr) begin
         unique case (regAddr)
            OFS_PA_DATA: paData_ff <= regWdata;
            OFS_PA_DIR:  paDir_ff  <= regWdata;
            OFS_PB_DATA: pbData_ff <= regWdata;
            OFS_PB_DIR:  pbDir_ff  <= regWdata;
            OFS_PC_DATA: pcData_ff <= regWdata;
            OFS_PC_DIR:  pcDir_ff  <= regWdata;
            default: ;
         endcase
      end
   end

   // wake enables, one per port a pin
   always_ff @(posedge clk or posedge rst) begin
      if (rst) paWake_ff <= RST_SEL;
      else if (regWr && regAddr == OFS_PA_WAKE) paWake_ff <= regWdata;
   end

   // ************************************************************
   // pin input synchronisers
   // ************************************************************
   logic [17:0] pinMeta_ff, pinSync_ff;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pinMeta_ff <= '1;
         pinSync_ff <= '1;
      end else begin
         pinMeta_ff <= {portcIn, portbIn, portaIn};
         pinSync_ff <= pinMeta_ff;
      end
   end
   logic [7:0] paPin;
   logic [3:0] pbPin;
   logic [5:0] pcPin;
   assign paPin = pinSync_ff[7:0];
   assign pbPin = pinSync_ff[11:8];
   assign pcPin = pinSync_ff[17:12];

   // read data one cycle after the strobe; bit ops rely on full-byte
   // read then full-byte write by the cpu, so no bit port is needed [RQ17]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) regRdata <= RST_SEL;
      else if (regRd) begin
         unique case (regAddr)
            OFS_PB_SEL:    regRdata <= pbSel_ff;
            OFS_PC_SEL_LO: regRdata <= pcSelLo_ff;
            OFS_PC_SEL_HI: regRdata <= pcSelHi_ff & MASK_PC_HI; // [RQ14]
            OFS_SRC_SEL:   regRdata <= srcSel_ff;
            OFS_PA_DATA:   regRdata <= paData_ff;
            OFS_PA_DIR:    regRdata <= paDir_ff;
            OFS_PB_DATA:   regRdata <= pbData_ff;
            OFS_PB_DIR:    regRdata <= pbDir_ff;
            OFS_PC_DATA:   regRdata <= pcData_ff;
            OFS_PC_DIR:    regRdata <= pcDir_ff;
            OFS_PA_WAKE:   regRdata <= paWake_ff;
            OFS_PA_PIN:    regRdata <= paPin;
            OFS_PB_PIN:    regRdata <= {4'h0, pbPin};
            OFS_PC_PIN:    regRdata <= {2'h0, pcPin};
            default:       regRdata <= 8'h00;
         endcase
      end else regRdata <= 8'h00;
   end

   // ************************************************************
   // output routing
   // ************************************************************
   // decode of one two-bit field to a driven function value
   function automatic logic [1:0] pickOut(input logic [1:0] sel, input logic gpio,
                                         input logic gpioOe, input logic fn01,
                                         input logic fn10, input logic fn11,
                                         input logic has10, input logic has11);
      logic [1:0] r;
      r = {gpioOe, gpio};
      if (sel == SEL_01) r = {1'b1, fn01};
      else if (sel == SEL_10 && has10) r = {1'b1, fn10};
      else if (sel == SEL_11 && has11) r = {1'b1, fn11};
      return r;
   endfunction

   logic [1:0] pbF [4];
   logic [1:0] pcF [6];
   logic [3:0] pbFn01;
   logic [3:0] pbHas11;
   logic [11:0] pcSelAll;
   logic [2:0] pbHall;
   // pb3 [RQ1], pb2 [RQ3], pb1 [RQ4], pb0 has no 01 function [RQ6]
   assign pbFn01  = {periphOut.timerOut[0], periphOut.timerOut[1],
                     periphOut.timerOut[1], 1'b0};
   assign pbHas11 = 4'b0111;
   assign pbHall  = {periphOut.hallOut[2], periphOut.hallOut[1], periphOut.hallOut[0]};
   // port c fields as one vector, so no pin ever slices out of range
   assign pcSelAll = {pcSelHi_ff[3:0], pcSelLo_ff};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pb
         logic [1:0] f;
         logic       p0;
         assign f  = pbSel_ff[2*gi +: 2];
         // pb0 code 01 keeps gpio
         assign p0 = (gi == 0) && (f == SEL_01);
         // direction 0 drives the pin as an output [RQ20]
         assign pbF[gi] = p0 ? {~pbDir_ff[gi], pbData_ff[gi]} :
                          pickOut(f, pbData_ff[gi], ~pbDir_ff[gi], pbFn01[gi],
                                  1'b0, pbHall[gi % 3],
                                  1'b0, pbHas11[gi]);
      end
      for (gi = 0; gi < 6; gi++) begin : g_pc
         logic [1:0] f;
         logic       tmr;
         assign f   = pcSelAll[2*gi +: 2];
         // pc0/1 timer0 [RQ10] [RQ11], pc2/3 timer2 [RQ8] [RQ9], pc4/5 timer3 [RQ12] [RQ13]
         assign tmr = (gi < 2) ? periphOut.timerOut[0] :
                      (gi < 4) ? periphOut.timerOut[2] : periphOut.timerOut[3];
         assign pcF[gi] = pickOut(f, pcData_ff[gi], ~pcDir_ff[gi], tmr,
                                  periphOut.gateOut[5-gi], 1'b0, 1'b1, 1'b0);
      end
   endgenerate

   // pins and analog enables from flip-flops; routing follows the written field
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         portaOut <= RST_PORT;
         portaOe  <= 8'h00;
         portbOut <= 4'hf;
         portbOe  <= 4'h0;
         portcOut <= 6'h3f;
         portcOe  <= 6'h00;
         analogEn <= '0;
      end else begin
         portaOut <= paData_ff;
         portaOe  <= ~paDir_ff; // [RQ20]
         for (int i = 0; i < 4; i++) begin
            portbOut[i] <= pbF[i][0];
            portbOe[i]  <= pbF[i][1] & (pbSel_ff[2*i +: 2] != SEL_10 || i == 3);
         end
         for (int i = 0; i < 6; i++) begin
            portcOut[i] <= pcF[i][0];
            portcOe[i]  <= pcF[i][1];
         end
         // analog channels 0..2 live on pb2, pb1, pb0 with code 10
         analogEn.analogCh <= {pbSel_ff[1:0] == SEL_10, pbSel_ff[3:2] == SEL_10,
                               pbSel_ff[5:4] == SEL_10};
      end
   end

   // ************************************************************
   // input routing to peripherals
   // ************************************************************
   logic [1:0] irqSrc, nfSrc;
   assign irqSrc = srcSel_ff[SRC_IRQ_LSB +: 2];
   assign nfSrc  = srcSel_ff[SRC_NF_LSB +: 2];
   // inputs stay reachable in gpio codes; software keeps source and field in step
   always_ff @(posedge clk or posedge rst) begin
      if (rst) periphIn <= '1;
      else begin
         unique case (irqSrc) // [RQ21] [RQ2] [RQ7]
            SEL_01:  periphIn.extIrq1In <= pbPin[3];
            SEL_10:  periphIn.extIrq1In <= pbPin[0];
            default: periphIn.extIrq1In <= paPin[7];
         endcase
         periphIn.captureTimerIn <= srcSel_ff[SRC_CAP_BIT] ? paPin[6] : pbPin[1]; // [RQ22] [RQ5]
         unique case (nfSrc) // [RQ23]
            SEL_01:  periphIn.noiseFilterIn <= paPin[6];
            SEL_10:  periphIn.noiseFilterIn <= pbPin[0];
            default: periphIn.noiseFilterIn <= paPin[7];
         endcase
         periphIn.timer0CapIn <= pbPin[2]; // [RQ3]
         periphIn.timer3ClkIn <= pbPin[2];
         periphIn.timer2ClkIn <= pbPin[1]; // [RQ4]
         periphIn.timer0ClkIn <= pbPin[3]; // [RQ1] [RQ19]
      end
   end

   // ************************************************************
   // port a wake on falling edge
   // ************************************************************
   logic [7:0] paPrev_ff;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) paPrev_ff <= RST_PORT;
      else paPrev_ff <= paPin;
   end
   // one-cycle pulse; gated by sleep so a run-mode edge does not wake later
   always_ff @(posedge clk or posedge rst) begin
      if (rst) wakeReq <= 1'b0;
      else wakeReq <= sleepMode && |(paPrev_ff & ~paPin & paWake_ff); // [RQ18]
   end

   // ************************************************************
   // checks
   // ************************************************************
   chk_pc_hi_zero: assert property (@(posedge clk) disable iff (rst) // [RQ14]
      regRd && regAddr == OFS_PC_SEL_HI |=> regRdata[7:4] == 4'h0)
      else $error("upper port c select bits not zero");
   chk_pb3_timer: assert property (@(posedge clk) disable iff (rst) // [RQ1]
      pbSel_ff[7:6] == SEL_01 |=> portbOe[3] && portbOut[3] == $past(periphOut.timerOut[0]))
      else $error("pb3 not driving timer0");
   chk_pb0_hall: assert property (@(posedge clk) disable iff (rst) // [RQ6]
      pbSel_ff[1:0] == SEL_11 |=> portbOe[0] && portbOut[0] == $past(periphOut.hallOut[0]))
      else $error("pb0 not driving hall a");
   chk_pc0_gate: assert property (@(posedge clk) disable iff (rst) // [RQ11]
      pcSelLo_ff[1:0] == SEL_10 |=> portcOe[0] && portcOut[0] == $past(periphOut.gateOut[5]))
      else $error("pc0 not driving gate a top");
   chk_pc5_gpio: assert property (@(posedge clk) disable iff (rst) // [RQ12]
      pcSelHi_ff[3:2] == SEL_11 |=> portcOe[5] == !$past(pcDir_ff[5]))
      else $error("pc5 code 11 not gpio");
   chk_dir_output: assert property (@(posedge clk) disable iff (rst) // [RQ20]
      regWr && regAddr == OFS_PA_DIR ##1 1'b1 |=> portaOe == ~$past(regWdata, 2))
      else $error("port a direction not applied");
   chk_sel_route: assert property (@(posedge clk) disable iff (rst) // [RQ24]
      regWr && regAddr == OFS_PC_SEL_LO && regWdata[3:2] == SEL_01
      |=> ##1 portcOe[1])
      else $error("pc1 routing not updated");
   chk_wake_edge: assert property (@(posedge clk) disable iff (rst) // [RQ18]
      wakeReq |-> $past(sleepMode) && |($past(paPrev_ff) & ~$past(paPin) & $past(paWake_ff)))
      else $error("wake without enabled falling edge");
   chk_irq_src: assert property (@(posedge clk) disable iff (rst) // [RQ21]
      irqSrc == SEL_10 |=> periphIn.extIrq1In == $past(pbPin[0]))
      else $error("irq1 source not pb0");
   // remaining pin fields and input sources, one check per rule
   chk_pb3_gpio: assert property (@(posedge clk) disable iff (rst) // [RQ1]
      pbSel_ff[7:6] == SEL_10 |=> portbOe[3] == !$past(pbDir_ff[3]))
      else $error("pb3 code 10 not gpio");
   chk_pb2_analog: assert property (@(posedge clk) disable iff (rst) // [RQ3]
      pbSel_ff[5:4] == SEL_10 |=> !portbOe[2] && analogEn.analogCh[0])
      else $error("pb2 analog not released");
   chk_pb1_hall: assert property (@(posedge clk) disable iff (rst) // [RQ4]
      pbSel_ff[3:2] == SEL_11 |=> portbOe[1] && portbOut[1] == $past(periphOut.hallOut[1]))
      else $error("pb1 not driving hall b");
   chk_pb0_analog: assert property (@(posedge clk) disable iff (rst) // [RQ6]
      pbSel_ff[1:0] == SEL_10 |=> !portbOe[0] && analogEn.analogCh[2])
      else $error("pb0 analog not released");
   chk_pc3_timer: assert property (@(posedge clk) disable iff (rst) // [RQ8]
      pcSelLo_ff[7:6] == SEL_01 |=> portcOe[3] && portcOut[3] == $past(periphOut.timerOut[2]))
      else $error("pc3 not driving timer2");
   chk_pc2_gate: assert property (@(posedge clk) disable iff (rst) // [RQ9]
      pcSelLo_ff[5:4] == SEL_10 |=> portcOe[2] && portcOut[2] == $past(periphOut.gateOut[3]))
      else $error("pc2 not driving gate b top");
   chk_pc1_timer: assert property (@(posedge clk) disable iff (rst) // [RQ10]
      pcSelLo_ff[3:2] == SEL_01 |=> portcOe[1] && portcOut[1] == $past(periphOut.timerOut[0]))
      else $error("pc1 not driving timer0");
   chk_pc4_timer: assert property (@(posedge clk) disable iff (rst) // [RQ13]
      pcSelHi_ff[1:0] == SEL_01 |=> portcOe[4] && portcOut[4] == $past(periphOut.timerOut[3]))
      else $error("pc4 not driving timer3");
   chk_irq_pb3: assert property (@(posedge clk) disable iff (rst) // [RQ21]
      irqSrc == SEL_01 |=> periphIn.extIrq1In == $past(pbPin[3]))
      else $error("irq1 source not pb3");
   chk_cap_src: assert property (@(posedge clk) disable iff (rst) // [RQ22]
      srcSel_ff[SRC_CAP_BIT] |=> periphIn.captureTimerIn == $past(paPin[6]))
      else $error("capture source not pa6");
   chk_nf_src: assert property (@(posedge clk) disable iff (rst) // [RQ23]
      nfSrc == SEL_01 |=> periphIn.noiseFilterIn == $past(paPin[6]))
      else $error("filter source not pa6");
   cov_pb2_analog: cover property (@(posedge clk) analogEn.analogCh[0]);
   cov_pb3_timer:  cover property (@(posedge clk) pbSel_ff[7:6] == SEL_01 && portbOe[3]);
   cov_nf_pb0:     cover property (@(posedge clk) nfSrc == SEL_10);
   cov_wake:       cover property (@(posedge clk) wakeReq);
   cov_pc4_gate:   cover property (@(posedge clk) pcSelHi_ff[1:0] == SEL_10 && portcOe[4]);
endmodule

//--- inc/pin_mux_pkg.sv
// package: register map, field layout, reset values and carrier types of the pin-function mux
package pin_mux_pkg;
   // register offsets (plain port index)
   localparam logic [3:0] OFS_PB_SEL    = 4'h0;
   localparam logic [3:0] OFS_PC_SEL_LO = 4'h1;
   localparam logic [3:0] OFS_PC_SEL_HI = 4'h2;
   localparam logic [3:0] OFS_SRC_SEL   = 4'h3;
   localparam logic [3:0] OFS_PA_DATA   = 4'h4;
   localparam logic [3:0] OFS_PA_DIR    = 4'h5;
   localparam logic [3:0] OFS_PB_DATA   = 4'h6;
   localparam logic [3:0] OFS_PB_DIR    = 4'h7;
   localparam logic [3:0] OFS_PC_DATA   = 4'h8;
   localparam logic [3:0] OFS_PC_DIR    = 4'h9;
   localparam logic [3:0] OFS_PA_WAKE   = 4'ha;
   localparam logic [3:0] OFS_PA_PIN    = 4'hb;
   localparam logic [3:0] OFS_PB_PIN    = 4'hc;
   localparam logic [3:0] OFS_PC_PIN    = 4'hd;
   // reset values and masks
   localparam logic [7:0] RST_SEL       = 8'h00;
   localparam logic [7:0] RST_PORT      = 8'hff;
   localparam logic [7:0] MASK_PC_HI    = 8'h0f;
   localparam logic [7:0] MASK_SRC      = 8'h7c;
   // source select field positions
   localparam int SRC_IRQ_LSB = 5;
   localparam int SRC_CAP_BIT = 4;
   localparam int SRC_NF_LSB  = 2;
   // two-bit pin field codes
   localparam logic [1:0] SEL_00 = 2'h0;
   localparam logic [1:0] SEL_01 = 2'h1;
   localparam logic [1:0] SEL_10 = 2'h2;
   localparam logic [1:0] SEL_11 = 2'h3;

   // peripheral outputs towards the pins
   typedef struct packed {
      logic [3:0] timerOut;   // timer0..timer3 outputs
      logic [2:0] hallOut;    // c, b, a
      logic [5:0] gateOut;    // a_top,a_bot,b_top,b_bot,c_top,c_bot
   } periph_out_s;
   // routed inputs towards the peripherals
   typedef struct packed {
      logic       extIrq1In;
      logic       captureTimerIn;
      logic       noiseFilterIn;
      logic       timer0CapIn;
      logic       timer0ClkIn;
      logic       timer2ClkIn;
      logic       timer3ClkIn;
   } periph_in_s;
   // analog channel enables
   typedef struct packed {
      logic [2:0] analogCh;   // ch2, ch1, ch0
   } analog_en_s;
endpackage

//--- dv/cpu_bus_model.sv
// partner model: cpu side of the register port, byte writes and reads
`timescale 1ns/1ps
module cpu_bus_model (
   input  wire logic clk,
   output logic [3:0] regAddr,
   output logic [7:0] regWdata,
   output logic       regWr,
   output logic       regRd
);
   // idle bus at time zero
   initial begin
      regAddr = 4'h0;
      regWdata = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
   end
   // one-cycle write strobe; data inverted afterwards so stale bytes never look valid
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      regWdata <= ~d;
   endtask
   // one-cycle read strobe; the answer stands in the next cycle only
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
   endtask
endmodule

//--- dv/tb_port_pin_function_select.sv
// self-checking bench: register map, pin routing, input sources and wake of the pin mux
`timescale 1ns/1ps
module tb_port_pin_function_select
   import pin_mux_pkg::*;
;
   logic        clk;
   logic        rst;
   logic [3:0]  regAddr;
   logic [7:0]  regWdata;
   logic        regWr;
   logic        regRd;
   logic [7:0]  regRdata;
   logic [7:0]  portaIn;
   logic [3:0]  portbIn;
   logic [5:0]  portcIn;
   logic [7:0]  portaOut;
   logic [7:0]  portaOe;
   logic [3:0]  portbOut;
   logic [3:0]  portbOe;
   logic [5:0]  portcOut;
   logic [5:0]  portcOe;
   periph_out_s periphOut;
   periph_in_s  periphIn;
   periph_in_s  expIn;
   analog_en_s  analogEn;
   logic        sleepMode;
   logic        wakeReq;
   logic        rdSeen = 1'b0;
   logic [7:0]  expQ[$];
   logic [31:0] seed = 32'd30;
   logic [31:0] r32;
   logic [19:0] sel;
   logic [3:0]  oldHi;
   logic [3:0]  kk;
   logic [3:0]  dB;
   logic [5:0]  dC;
   int          numErrors = 0;
   int          nCompared = 0;
   // pb0..pb3 function presence: {analog on 10, has 11, has 10, has 01}
   localparam logic [15:0] HAS_B = {4'b0001, 4'b1101, 4'b1101, 4'b1100};

   port_pin_function_select dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .portaIn(portaIn), .portbIn(portbIn),
      .portcIn(portcIn), .portaOut(portaOut), .portaOe(portaOe), .portbOut(portbOut),
      .portbOe(portbOe), .portcOut(portcOut), .portcOe(portcOe), .periphOut(periphOut),
      .periphIn(periphIn), .analogEn(analogEn), .sleepMode(sleepMode), .wakeReq(wakeReq));
   cpu_bus_model cpu (.clk(clk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd));

   // ****************************************
   // helpers
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         numErrors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // expected {oe, out} of one pin; gpio pins have direction 0 so they drive data
   function automatic logic [1:0] pexp(input logic [1:0] c, input logic [3:0] has,
                                       input logic [2:0] f, input logic d);
      if (c == SEL_01 && has[0]) return {1'b1, f[0]};
      if (c == SEL_10 && has[3]) return 2'b00;
      if (c == SEL_10 && has[1]) return {1'b1, f[1]};
      if (c == SEL_11 && has[2]) return {1'b1, f[2]};
      return {1'b1, d};
   endfunction
   // packed view {b oe, b out, c oe, c out, analog}; out masked where nothing drives
   function automatic logic [31:0] expAll(input logic [7:0] pb, input logic [11:0] pc);
      logic [1:0]  r;
      logic [31:0] e;
      e = '0;
      for (int i = 0; i < 4; i++) begin
         r = pexp(pb[2*i+:2], HAS_B[4*i+:4], {periphOut.hallOut[i%3], 1'b0,
                  periphOut.timerOut[(i == 3) ? 0 : 1]}, dB[i]);
         e[19+i] = r[1];
         e[15+i] = r[1] & r[0];
      end
      for (int i = 0; i < 6; i++) begin
         r = pexp(pc[2*i+:2], 4'b0011, {1'b0, periphOut.gateOut[5-i],
                  periphOut.timerOut[(i < 2) ? 0 : i/2+1]}, dC[i]);
         e[9+i] = r[1];
         e[3+i] = r[1] & r[0];
      end
      e[2:0] = {pb[1:0] == SEL_10, pb[3:2] == SEL_10, pb[5:4] == SEL_10};
      return e;
   endfunction
   function automatic logic [31:0] obs();
      return {9'h0, portbOe, portbOut & portbOe, portcOe, portcOut & portcOe, analogEn.analogCh};
   endfunction
   // driver notes each expected read byte; the watcher pops it when the data stand
   task automatic rdx(input logic [3:0] a, input logic [7:0] e);
      expQ.push_back(e);
      cpu.rd(a);
   endtask
   always @(posedge clk) rdSeen <= regRd;
   always @(negedge clk) begin
      if (rdSeen)
         chk({24'h0, regRdata}, {24'h0, expQ.pop_front()});
   end
   // selection before use of the timer pins; routing moves on the second edge only
   task automatic muxCase(input logic [7:0] pb, input logic [11:0] pc);
      r32 = rnd();
      periphOut <= r32[12:0];
      cpu.wr(OFS_PB_SEL, pb);
      cpu.wr(OFS_PC_SEL_LO, pc[7:0]);
      cpu.wr(OFS_PC_SEL_HI, {4'h0, pc[11:8]});
      #1 chk(obs(), expAll(pb, {oldHi, pc[7:0]}));
      @(posedge clk);
      #1 chk(obs(), expAll(pb, pc));
   endtask
   task automatic wakeCount(input logic [7:0] pins, input int exp);
      int n;
      n = 0;
      portaIn <= pins;
      repeat (8) begin
         @(posedge clk);
         #1 n += int'(wakeReq === 1'b1);
      end
      chk(n, exp);
   endtask
   task automatic results();
      $display("compared %0d, mismatches %0d", nCompared, numErrors);
      if (numErrors == 0 && nCompared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // watchdog: all tests need well under a millisecond
   initial begin
      #2ms;
      numErrors++;
      $display("watchdog expired");
      results();
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rst = 1'b1;
      sleepMode = 1'b0;
      portaIn = 8'hff;
      portbIn = 4'hf;
      portcIn = 6'h3f;
      periphOut = '0;
      repeat (20) @(posedge clk);
      #1 chk({portaOe, portbOe, portcOe}, 0);
      chk({portbOut, portcOut}, 32'h3ff);
      chk(portaOut, 32'hff);
      @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 16; a++) begin
         if (a < 10 || a > 13)
            rdx(a[3:0], (a >= 4 && a <= 9) ? RST_PORT : RST_SEL);
      end
      cpu.wr(OFS_PC_SEL_HI, 8'hff);
      rdx(OFS_PC_SEL_HI, MASK_PC_HI);
      cpu.wr(OFS_PC_SEL_HI, 8'h00);
      cpu.wr(OFS_PC_DIR, 8'h00);
      repeat (2) @(posedge clk);
      #1 chk({portcOe, portcOut}, 32'hfff);
      rdx(OFS_PC_DATA, 8'hff);
      cpu.wr(OFS_PC_DATA, 8'hfb);
      repeat (2) @(posedge clk);
      #1 chk(portcOut, 32'h3b);
      cpu.wr(OFS_PA_DATA, 8'h5a);
      cpu.wr(OFS_PA_DIR, 8'h0f);
      repeat (2) @(posedge clk);
      #1 chk({portaOe, portaOut}, 32'hf05a);
      r32 = rnd();
      dB = r32[3:0];
      dC = r32[9:4];
      cpu.wr(OFS_PB_DIR, 8'h00);
      cpu.wr(OFS_PB_DATA, {4'h0, dB});
      cpu.wr(OFS_PC_DATA, {2'h0, dC});
      $display("test registers done");
      oldHi = 4'h0;
      for (int i = 0; i < 12; i++) begin
         r32 = rnd();
         sel = (i < 4) ? {10{i[1:0]}} : r32[19:0];
         muxCase(sel[19:12], sel[11:0]);
         oldHi = sel[11:8];
      end
      $display("test routing done");
      for (int k = 0; k < 16; k++) begin
         kk = k[3:0];
         cpu.wr(OFS_SRC_SEL, {1'b0, kk[3:2], kk[0], kk[1:0], 2'b00});
         cpu.wr(OFS_PB_SEL, 8'h00);
         r32 = rnd();
         portaIn <= r32[7:0];
         portbIn <= r32[11:8];
         portcIn <= r32[17:12];
         repeat (4) @(posedge clk);
         expIn.extIrq1In = (kk[3:2] == 2'h1) ? r32[11] : (kk[3:2] == 2'h2) ? r32[8] : r32[7];
         expIn.captureTimerIn = kk[0] ? r32[6] : r32[9];
         expIn.noiseFilterIn = (kk[1:0] == 2'h1) ? r32[6] : (kk[1:0] == 2'h2) ? r32[8] : r32[7];
         expIn.timer0CapIn = r32[10];
         expIn.timer0ClkIn = r32[11];
         expIn.timer2ClkIn = r32[9];
         expIn.timer3ClkIn = r32[10];
         #1 chk(32'(periphIn), 32'(expIn));
      end
      rdx(OFS_PA_PIN, r32[7:0]);
      rdx(OFS_PB_PIN, {4'h0, r32[11:8]});
      rdx(OFS_PC_PIN, {2'h0, r32[17:12]});
      rdx(OFS_SRC_SEL, 8'h7c);
      cpu.wr(OFS_SRC_SEL, 8'hff);
      rdx(OFS_SRC_SEL, MASK_SRC);
      $display("test input sources done");
      portaIn <= 8'hff;
      cpu.wr(OFS_PA_WAKE, 8'h01);
      sleepMode <= 1'b1;
      wakeCount(8'hff, 0);
      wakeCount(8'hfd, 0);
      wakeCount(8'hfc, 1);
      sleepMode <= 1'b0;
      wakeCount(8'hfd, 0);
      wakeCount(8'hfc, 0);
      $display("test wake done");
      repeat (3) @(posedge clk);
      results();
   end
endmodule
